// ---- rtl/cqm_top.sv ----
// Clock qualification monitors with APB register file
`timescale 1ns/10ps
`include "cqm_defs.svh"
// Contract
// - LOS window accepted when count lies within nominal +/- accept margin.
// - LOS window rejected when count lies outside nominal +/- reject margin.
// - 13-bit LOS nominal is expected system clocks per window, band centre.
// - LOS nominal zero disables monitor and holds LOS status asserted.
// - Activity status: 0 qualified, 1 disqualified, resets to 1.
// - Activity event sets whenever monitor disqualifies, stays until cleared.
// - Write one clears activity event, ignored while disqualified persists.
// - Activity event resets to 1; software clears after configuring.
// - Activity failure mask 1 treats clock as qualified regardless of status.
// - Monitored clock divided by 19-bit ratio forms window; aim near 100Hz.
// - Activity divide ratio zero acts as divide by one.
// - LOS qualifies after N accepts, fails after M rejects; zero acts as one.
// - LOS failure mask 1 removes LOS status from reference invalid.
// - One accepted activity window qualifies; one rejected disqualifies.
// - Activity counts ring oscillator divided by four against its nominal.
module cqm_top
    import cqm_pkg::*;
(
    input wire logic pclk, // System clock, 10 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire logic ref_clk_in, // Monitored reference clock, sampled
    input wire logic ring_tick, // Ring oscillator divided by four, pulse
    output logic ref_invalid_q, // Reference clock invalid
    output logic act_qualified_q, // Activity result after mask
    output logic act1_soft_reset_q // Soft reset for activity monitor one
);
    // Configuration registers
    logic [12:0] los_acc_q;
    logic [12:0] los_rej_q;
    logic [12:0] los_nom_q;
    cqm_times_t los_good_times_q;
    cqm_times_t los_fail_times_q;
    logic los_mask_q;
    logic [4:0] los_ratio_q;
    logic act_mask_q;
    cqm_ratio_t act_ratio_q;
    cqm_cnt_t act_acc_q;
    cqm_cnt_t act_rej_q;
    cqm_cnt_t act_nom_q;
    logic act0_soft_reset_q;
    // Monitor state
    logic los_sts_q;
    cqm_times_t los_good_q;
    cqm_times_t los_fail_q;
    logic act_sts_q;
    logic act_evt_q;
    logic ref_clk_q;
    logic mon_edge;
    // APB decode
    logic setup;
    logic wr_en;
    logic evt_clr;
    logic mapped;
    logic [31:0] rdata_d;
    // Window results
    logic los_done;
    cqm_cnt_t los_count;
    logic los_accept;
    logic los_reject;
    logic act_done;
    cqm_cnt_t act_count;
    logic act_accept;
    logic act_reject;
    logic los_on;
    logic act_on;
    cqm_times_t good_lim;
    cqm_times_t fail_lim;
    logic [4:0] good_next;
    logic [4:0] fail_next;

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite && mapped;
    assign evt_clr = wr_en && paddr == `CQM_OFF_ACT_EVENT && pwdata[0];
    assign mon_edge = ref_clk_in && !ref_clk_q;
    assign los_on = los_nom_q != 13'h0;
    assign act_on = act_nom_q != 22'h0 && !act0_soft_reset_q;
    assign good_lim = (los_good_times_q == 4'h0) ? 4'h1 : los_good_times_q;
    assign fail_lim = (los_fail_times_q == 4'h0) ? 4'h1 : los_fail_times_q;
    assign good_next = {1'b0, los_good_q} + 5'h1;
    assign fail_next = {1'b0, los_fail_q} + 5'h1;

    // Address decode; unmapped offsets answer with an error
    always_comb begin
        case (paddr)
            `CQM_OFF_LOS_THRESH, `CQM_OFF_LOS_NOMINAL, `CQM_OFF_ACT_STS,
            `CQM_OFF_ACT_EVENT, `CQM_OFF_ACT_WINDOW, `CQM_OFF_LOS_CFG,
            `CQM_OFF_ACT_ACC, `CQM_OFF_ACT_REJ, `CQM_OFF_ACT_NOM,
            `CQM_OFF_CTRL, `CQM_OFF_LOS_STS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // Read mux; every unlisted bit reads zero
    always_comb begin
        rdata_d = 32'h0;
        case (paddr)
            `CQM_OFF_LOS_THRESH: begin
                rdata_d[`CQM_LOS_ACC_MSB:`CQM_LOS_ACC_LSB] = los_acc_q;
                rdata_d[`CQM_LOS_REJ_MSB:0] = los_rej_q;
            end
            `CQM_OFF_LOS_NOMINAL: rdata_d[`CQM_LOS_NOM_MSB:0] = los_nom_q;
            `CQM_OFF_ACT_STS: rdata_d[0] = act_sts_q;
            `CQM_OFF_ACT_EVENT: rdata_d[0] = act_evt_q;
            `CQM_OFF_ACT_WINDOW: begin
                rdata_d[`CQM_ACT_MASK_BIT] = act_mask_q;
                rdata_d[`CQM_ACT_RATIO_MSB:0] = act_ratio_q;
            end
            `CQM_OFF_LOS_CFG: begin
                rdata_d[`CQM_LOS_GOOD_MSB:`CQM_LOS_GOOD_LSB] =
                    los_good_times_q;
                rdata_d[`CQM_LOS_FAIL_MSB:0] = los_fail_times_q;
                rdata_d[`CQM_LOS_MASK_BIT] = los_mask_q;
                rdata_d[`CQM_LOS_RATIO_MSB:`CQM_LOS_RATIO_LSB] = los_ratio_q;
            end
            `CQM_OFF_ACT_ACC: rdata_d[`CQM_ACT_MARGIN_MSB:0] = act_acc_q;
            `CQM_OFF_ACT_REJ: rdata_d[`CQM_ACT_MARGIN_MSB:0] = act_rej_q;
            `CQM_OFF_ACT_NOM: rdata_d[`CQM_ACT_MARGIN_MSB:0] = act_nom_q;
            `CQM_OFF_CTRL: begin
                rdata_d[`CQM_CTRL_RST0_BIT] = act0_soft_reset_q;
                rdata_d[`CQM_CTRL_RST1_BIT] = act1_soft_reset_q;
            end
            `CQM_OFF_LOS_STS: begin
                rdata_d[0] = los_sts_q;
                rdata_d[1] = ref_invalid_q;
            end
            default: rdata_d = 32'h0;
        endcase
    end

    // Answer is prepared in setup so the access phase needs no wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup) begin
                prdata <= pwrite ? 32'h0 : rdata_d;
                pslverr <= !mapped;
            end
        end
    end

    // Writable fields; only documented bit positions are stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            los_acc_q <= 13'h0;
            los_rej_q <= 13'h0;
            los_nom_q <= 13'h0;
            los_good_times_q <= 4'h0;
            los_fail_times_q <= 4'h0;
            los_mask_q <= 1'b0;
            los_ratio_q <= 5'h0;
            act_mask_q <= 1'b0;
            act_ratio_q <= 19'h0;
            act_acc_q <= 22'h0;
            act_rej_q <= 22'h0;
            act_nom_q <= 22'h0;
            act0_soft_reset_q <= 1'b0;
            act1_soft_reset_q <= 1'b0;
        end else if (wr_en) begin
            case (paddr)
                `CQM_OFF_LOS_THRESH: begin
                    los_acc_q <= pwdata[`CQM_LOS_ACC_MSB:`CQM_LOS_ACC_LSB];
                    los_rej_q <= pwdata[`CQM_LOS_REJ_MSB:0];
                end
                `CQM_OFF_LOS_NOMINAL: los_nom_q <= pwdata[`CQM_LOS_NOM_MSB:0];
                `CQM_OFF_ACT_WINDOW: begin
                    act_mask_q <= pwdata[`CQM_ACT_MASK_BIT];
                    act_ratio_q <= pwdata[`CQM_ACT_RATIO_MSB:0];
                end
                `CQM_OFF_LOS_CFG: begin
                    los_good_times_q <=
                        pwdata[`CQM_LOS_GOOD_MSB:`CQM_LOS_GOOD_LSB];
                    los_fail_times_q <= pwdata[`CQM_LOS_FAIL_MSB:0];
                    los_mask_q <= pwdata[`CQM_LOS_MASK_BIT];
                    los_ratio_q <=
                        pwdata[`CQM_LOS_RATIO_MSB:`CQM_LOS_RATIO_LSB];
                end
                `CQM_OFF_ACT_ACC: act_acc_q <= pwdata[`CQM_ACT_MARGIN_MSB:0];
                `CQM_OFF_ACT_REJ: act_rej_q <= pwdata[`CQM_ACT_MARGIN_MSB:0];
                `CQM_OFF_ACT_NOM: act_nom_q <= pwdata[`CQM_ACT_MARGIN_MSB:0];
                `CQM_OFF_CTRL: begin
                    act0_soft_reset_q <= pwdata[`CQM_CTRL_RST0_BIT];
                    act1_soft_reset_q <= pwdata[`CQM_CTRL_RST1_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // Edge detect on the monitored clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_clk_q <= 1'b0;
        end else begin
            ref_clk_q <= ref_clk_in;
        end
    end

    // LOS window counts system clocks, so every cycle is a tick
    cqm_window u_los_window (
        .pclk(pclk),
        .presetn(presetn),
        .clr(!los_on),
        .mon_edge(mon_edge),
        .ref_tick(1'b1),
        .div_ratio({14'h0, los_ratio_q}),
        .done(los_done),
        .count(los_count)
    );

    cqm_judge u_los_judge (
        .count(los_count),
        .nominal({9'h0, los_nom_q}),
        .acc_margin({9'h0, los_acc_q}),
        .rej_margin({9'h0, los_rej_q}),
        .accept(los_accept),
        .reject(los_reject)
    );

    // Activity window counts ticks of the ring oscillator divided by four
    cqm_window u_act_window (
        .pclk(pclk),
        .presetn(presetn),
        .clr(!act_on),
        .mon_edge(mon_edge),
        .ref_tick(ring_tick),
        .div_ratio(act_ratio_q),
        .done(act_done),
        .count(act_count)
    );

    cqm_judge u_act_judge (
        .count(act_count),
        .nominal(act_nom_q),
        .acc_margin(act_acc_q),
        .rej_margin(act_rej_q),
        .accept(act_accept),
        .reject(act_reject)
    );

    // LOS qualification counters; accept wins if both bands overlap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            los_sts_q <= `CQM_LOS_STS_RST;
            los_good_q <= 4'h0;
            los_fail_q <= 4'h0;
        end else if (!los_on) begin
            los_sts_q <= 1'b1;
            los_good_q <= 4'h0;
            los_fail_q <= 4'h0;
        end else if (los_done && los_accept) begin
            if (good_next >= {1'b0, good_lim}) begin
                los_sts_q <= 1'b0;
                los_good_q <= 4'h0;
                los_fail_q <= 4'h0;
            end else begin
                los_good_q <= good_next[3:0];
            end
        end else if (los_done && los_reject) begin
            los_good_q <= 4'h0;
            if (fail_next >= {1'b0, fail_lim}) begin
                los_sts_q <= 1'b1;
                los_fail_q <= 4'h0;
            end else begin
                los_fail_q <= fail_next[3:0];
            end
        end
    end // A neutral window falls through untouched

    // Activity result follows a single window; disabled means disqualified
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_sts_q <= `CQM_ACT_STS_RST;
        end else if (!act_on) begin
            act_sts_q <= 1'b1;
        end else if (act_done && act_accept) begin
            act_sts_q <= 1'b0;
        end else if (act_done && act_reject) begin
            act_sts_q <= 1'b1;
        end
    end

    // Sticky event; the disqualified level beats a same-cycle clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_evt_q <= `CQM_ACT_EVT_RST;
        end else begin
            act_evt_q <= act_sts_q || (act_evt_q && !evt_clr);
        end
    end

    // Masked results; invalid lags status by one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_invalid_q <= 1'b1;
            act_qualified_q <= 1'b0;
        end else begin
            act_qualified_q <= act_mask_q || !act_sts_q;
            ref_invalid_q <= (los_sts_q && !los_mask_q) ||
                (act_sts_q && !act_mask_q);
        end
    end

    los_disable_a: assert property (@(posedge pclk) disable iff (!presetn)
        (los_nom_q == 13'h0) |=> los_sts_q)
        else $error("zero nominal did not hold loss status");
    los_neutral_a: assert property (@(posedge pclk) disable iff (!presetn)
        (los_on && !(los_done && (los_accept || los_reject)))
        |=> ($stable(los_good_q) && $stable(los_fail_q)))
        else $error("neutral window moved qualification counters");
    los_fail_one_a: assert property (@(posedge pclk) disable iff (!presetn)
        (los_on && los_done && !los_accept && los_reject &&
         los_fail_times_q <= 4'h1) |=> los_sts_q)
        else $error("single rejected window did not disqualify");
    los_qualify_a: assert property (@(posedge pclk) disable iff (!presetn)
        (los_on && los_done && los_accept && good_next >= {1'b0, good_lim})
        |=> (!los_sts_q && los_good_q == 4'h0))
        else $error("accepted windows did not qualify");
    act_accept_a: assert property (@(posedge pclk) disable iff (!presetn)
        (act_on && act_done && act_accept) |=> !act_sts_q)
        else $error("accepted activity window did not qualify");
    act_reject_a: assert property (@(posedge pclk) disable iff (!presetn)
        (act_on && act_done && !act_accept && act_reject) |=> act_sts_q)
        else $error("rejected activity window did not disqualify");
    evt_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
        act_sts_q |=> act_evt_q)
        else $error("event not set while disqualified");
    evt_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (evt_clr && !act_sts_q) |=> !act_evt_q)
        else $error("write one did not clear event");
    mask_invalid_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 ref_invalid_q == $past((los_sts_q && !los_mask_q) ||
            (act_sts_q && !act_mask_q)))
        else $error("reference invalid ignores masks");
    rsvd_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && paddr == `CQM_OFF_ACT_STS)
        |=> prdata[31:1] == 31'h0)
        else $error("reserved status bits read nonzero");
endmodule

// ---- rtl/cqm_defs.svh ----
// Offsets, field positions, reset values for the clock qualification monitors
`ifndef CQM_DEFS_SVH
`define CQM_DEFS_SVH

// Register byte offsets
`define CQM_OFF_LOS_THRESH 8'h00
`define CQM_OFF_LOS_NOMINAL 8'h04
`define CQM_OFF_ACT_STS 8'h08
`define CQM_OFF_ACT_EVENT 8'h0c
`define CQM_OFF_ACT_WINDOW 8'h10
`define CQM_OFF_LOS_CFG 8'h14
`define CQM_OFF_ACT_ACC 8'h18
`define CQM_OFF_ACT_REJ 8'h1c
`define CQM_OFF_ACT_NOM 8'h20
`define CQM_OFF_CTRL 8'h24
`define CQM_OFF_LOS_STS 8'h28

// Field positions
`define CQM_LOS_ACC_MSB 28
`define CQM_LOS_ACC_LSB 16
`define CQM_LOS_REJ_MSB 12
`define CQM_LOS_NOM_MSB 12
`define CQM_ACT_MASK_BIT 20
`define CQM_ACT_RATIO_MSB 18
`define CQM_ACT_MARGIN_MSB 21
`define CQM_LOS_GOOD_MSB 7
`define CQM_LOS_GOOD_LSB 4
`define CQM_LOS_FAIL_MSB 3
`define CQM_LOS_MASK_BIT 8
`define CQM_LOS_RATIO_MSB 20
`define CQM_LOS_RATIO_LSB 16
`define CQM_CTRL_RST0_BIT 0
`define CQM_CTRL_RST1_BIT 1

// Reset values
`define CQM_ACT_STS_RST 1'b1
`define CQM_ACT_EVT_RST 1'b1
`define CQM_LOS_STS_RST 1'b1

`endif

// ---- rtl/cqm_pkg.sv ----
// Types shared by the clock qualification monitor files
package cqm_pkg;
    typedef logic [21:0] cqm_cnt_t;
    typedef logic [18:0] cqm_ratio_t;
    typedef logic [3:0] cqm_times_t;
endpackage

// ---- rtl/cqm_window.sv ----
// Window counter: counts reference ticks over div_ratio monitored edges
`timescale 1ns/10ps
`include "cqm_defs.svh"
module cqm_window
    import cqm_pkg::*;
(
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    input wire logic clr, // Holds the window idle
    input wire logic mon_edge, // Rising edge of monitored clock
    input wire logic ref_tick, // One reference period elapsed
    input wire cqm_ratio_t div_ratio, // Monitored edges per window
    output logic done, // Window finished, one cycle
    output cqm_cnt_t count // Final count of the window
);
    logic started_q;
    cqm_ratio_t edge_q;
    cqm_cnt_t run_q;
    cqm_ratio_t limit;
    logic [19:0] edge_next;

    // Zero acts as divide by one
    assign limit = (div_ratio == 19'h0) ? 19'h1 : div_ratio;
    assign edge_next = {1'b0, edge_q} + 20'h1;

    // First edge only arms the counter, so no partial window is judged
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            started_q <= 1'b0;
            edge_q <= 19'h0;
            run_q <= 22'h0;
            done <= 1'b0;
            count <= 22'h0;
        end else if (clr) begin
            started_q <= 1'b0;
            edge_q <= 19'h0;
            run_q <= 22'h0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (ref_tick && run_q != 22'h3fffff) begin
                run_q <= run_q + 22'h1; // Saturates on a dead clock
            end
            if (mon_edge) begin
                if (!started_q) begin
                    started_q <= 1'b1;
                    run_q <= ref_tick ? 22'h1 : 22'h0; // As a later window
                end else if (edge_next >= {1'b0, limit}) begin
                    edge_q <= 19'h0;
                    done <= 1'b1;
                    count <= run_q;
                    run_q <= ref_tick ? 22'h1 : 22'h0;
                end else begin
                    edge_q <= edge_next[18:0];
                end
            end
        end
    end

    window_div1_a: assert property (@(posedge pclk) disable iff (!presetn)
        (div_ratio <= 19'h1 && started_q && mon_edge && !clr) |=> done)
        else $error("divide ratio of zero or one did not close window");
endmodule

// ---- rtl/cqm_judge.sv ----
// Window judge: accept and reject bands around the nominal count
`timescale 1ns/10ps
module cqm_judge
    import cqm_pkg::*;
(
    input wire cqm_cnt_t count, // Final window count
    input wire cqm_cnt_t nominal, // Expected count, band centre
    input wire cqm_cnt_t acc_margin, // Accept half width
    input wire cqm_cnt_t rej_margin, // Reject half width
    output logic accept, // Count within accept band
    output logic reject // Count outside reject band
);
    cqm_cnt_t diff;

    // Distance from nominal, then band checks
    always_comb begin
        diff = (count >= nominal) ? count - nominal : nominal - count;
        accept = diff <= acc_margin;
        reject = diff > rej_margin;
    end
endmodule

// ---- testbench/cqm_clk_src.sv ----
// Model of the monitored reference clock and the divided ring oscillator
`timescale 1ns/10ps
module cqm_clk_src (
    input wire logic pclk, // System clock
    input wire logic [7:0] period, // Reference period in pclk cycles, 0 stops
    input wire logic [3:0] gap, // Cycles between ring ticks, 0 stops
    output logic ref_clk_in, // Monitored reference clock
    output logic ring_tick // One pulse per ring period
);
    logic [7:0] ph_q = 8'h00;
    logic [7:0] per_q = 8'h00;
    logic [3:0] tk_q = 4'h0;
    // Reference clock, half high half low; stays low when stopped.
    // A new period is taken only at a wrap, so a change never makes a
    // runt cycle that the monitor would judge as a short window.
    always_ff @(posedge pclk) begin
        if (per_q == 8'h00 || ph_q >= per_q - 8'h01) begin
            ph_q <= 8'h00;
            per_q <= period;
        end else begin
            ph_q <= ph_q + 8'h01;
        end
        ref_clk_in <= (per_q != 8'h00) && (ph_q < (per_q >> 1));
    end
    // Ring ticks are single cycle pulses so the counter sees each once
    always_ff @(posedge pclk) begin
        if (gap == 4'h0 || tk_q >= gap - 4'h1) begin
            tk_q <= 4'h0;
            ring_tick <= (gap != 4'h0);
        end else begin
            tk_q <= tk_q + 4'h1;
            ring_tick <= 1'b0;
        end
    end
endmodule

// ---- testbench/tb_top.sv ----
// Register level test of the clock qualification monitors
`timescale 1ns/10ps
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ref_clk;
    logic ring, ref_invalid, act_qual, act1_rst;
    logic [7:0] paddr, period;
    logic [3:0] gap;
    logic [31:0] pwdata, prdata, rd;
    int num_errors = 0;
    int total_checks = 0;
    cqm_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ref_clk_in(ref_clk), .ring_tick(ring), .ref_invalid_q(ref_invalid),
        .act_qualified_q(act_qual), .act1_soft_reset_q(act1_rst));
    cqm_clk_src src (.pclk(pclk), .period(period), .gap(gap),
        .ref_clk_in(ref_clk), .ring_tick(ring));
    // Clock, 100 ns period
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: saw %h expected %h",
                $time, seen, exp);
        end
    endtask
    task automatic conclude;
        $display("errors %0d checks %0d", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // One APB transfer; holds the request until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            chk(32'h0, 32'h1);
            conclude();
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Watchdog, well beyond the thousand or so cycles the tests need
    initial begin
        #2000000;
        num_errors++;
        conclude();
    end
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite} = 3'b000;
        paddr = 8'h00;
        pwdata = 32'h0;
        period = 8'h0a;
        gap = 4'h0;
        idle(20);
        presetn <= 1'b1;
        // Reset values and access kinds
        rdchk(8'h08, 32'h1);
        rdchk(8'h0c, 32'h1);
        rdchk(8'h28, 32'h3);
        rdchk(8'h10, 32'h0);
        chk({31'h0, ref_invalid}, 32'h1);
        // Reserved bits and read only places; ratio kept off all ones
        wr(8'h00, 32'hffffffff);
        rdchk(8'h00, 32'h1fff1fff);
        wr(8'h04, 32'hffffffff);
        rdchk(8'h04, 32'h00001fff);
        wr(8'h10, 32'hfff7fffe);
        rdchk(8'h10, 32'h0017fffe);
        wr(8'h08, 32'h0);
        rdchk(8'h08, 32'h1);
        apb(1'b0, 8'h40, 32'h0);
        chk({pslverr, rd[30:0]}, 32'h80000000);
        // LOS: nominal 10, accept 1, reject 3, divide by 1; activity masked
        wr(8'h10, 32'h00100000);
        wr(8'h04, 32'h0000000a);
        wr(8'h00, 32'h00010003);
        wr(8'h14, 32'h00010000);
        idle(100);
        rdchk(8'h28, 32'h0);
        chk({31'h0, ref_invalid}, 32'h0);
        period <= 8'h0c; // Between the bands: no change
        idle(100);
        rdchk(8'h28, 32'h0);
        period <= 8'h0e;
        idle(100);
        rdchk(8'h28, 32'h3);
        // Eight accepted windows needed: a few windows in, still failed
        wr(8'h14, 32'h00010080);
        period <= 8'h0a;
        idle(36);
        rdchk(8'h28, 32'h3);
        idle(100);
        rdchk(8'h28, 32'h0);
        wr(8'h04, 32'h0);
        idle(3);
        rdchk(8'h28, 32'h3);
        wr(8'h14, 32'h00010100);
        idle(3);
        rdchk(8'h28, 32'h1);
        // Activity: 40 cycle window, 20 ticks nominal; soft reset held
        wr(8'h24, 32'h3);
        idle(1); // Output register updates at the access edge
        chk({31'h0, act1_rst}, 32'h1);
        wr(8'h10, 32'h00000004);
        wr(8'h20, 32'h14);
        wr(8'h18, 32'h2);
        wr(8'h1c, 32'h5);
        wr(8'h24, 32'h0);
        gap <= 4'h2;
        idle(200);
        rdchk(8'h08, 32'h0);
        chk({31'h0, act_qual}, 32'h1);
        wr(8'h0c, 32'h1);
        rdchk(8'h0c, 32'h0);
        gap <= 4'h4; // Ten ticks per window: rejected
        idle(200);
        rdchk(8'h08, 32'h1);
        rdchk(8'h0c, 32'h1);
        wr(8'h0c, 32'h1);
        rdchk(8'h0c, 32'h1);
        chk({31'h0, act_qual}, 32'h0);
        wr(8'h10, 32'h00100004);
        idle(3);
        chk({31'h0, act_qual}, 32'h1);
        // Ratio zero: one edge per window, five ticks
        wr(8'h24, 32'h1);
        wr(8'h10, 32'h0);
        wr(8'h20, 32'h5);
        wr(8'h24, 32'h0);
        gap <= 4'h2;
        idle(100);
        rdchk(8'h08, 32'h0);
        conclude();
    end
endmodule
